// ### src/rdv_pkg.sv
package rdv_pkg;

    // Default number of voted discrete inputs
    localparam int NUM_INPUTS = 16;

    // Input image areas, in the order they appear
    localparam int AREA_VOTED = 0;
    localparam int AREA_COPY_A = 1;
    localparam int AREA_COPY_B = 2;
    localparam int AREA_COPY_C = 3;
    localparam int AREA_NONVOTED = 4;
    localparam int AREA_RESERVED = 5;
    localparam int AREA_COUNT = 6;

    // Valid copy counts
    localparam logic [1:0] COUNT_NONE = 2'h0;
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_TWO = 2'h2;
    localparam logic [1:0] COUNT_ALL = 2'h3;

    // Reset values
    localparam logic VOTED_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;

    // Redundancy of an input group
    typedef enum logic [1:0] {
        GROUP_NONVOTED,
        GROUP_SIMPLEX,
        GROUP_DUPLEX,
        GROUP_TRIPLEX
    } rdv_group_type;

    // How far a group degrades
    typedef enum logic {
        ADAPT_FULL,
        ADAPT_STOP_AT_TWO
    } rdv_adapt_type;

    // Per input configuration
    typedef struct packed {
        rdv_group_type group;
        rdv_adapt_type adapt;
        logic tiebreak;
        logic default_state;
    } rdv_cfg_type;

    // One bit for each redundant copy
    typedef struct packed {
        logic c;
        logic b;
        logic a;
    } rdv_copy_type;

    // Sweep sequencing
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_VOTE,
        ST_REPORT
    } rdv_state_type;

endpackage : rdv_pkg

// ### src/rdv_voter.sv
`timescale 1ns/1ps
`default_nettype none

module rdv_voter #(
    parameter int NUM_INPUTS = rdv_pkg::NUM_INPUTS
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Input scan
    input wire logic scan_done_in,
    input wire rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] copy_in,
    input wire logic [NUM_INPUTS-1:0] nonvoted_in,
    input wire logic [NUM_INPUTS-1:0] manual_inhibit_in,
    // Copy faults from the input blocks
    input wire rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] selftest_fault_in,
    input wire rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] comm_fault_in,
    // Configuration and fault clearing
    input wire rdv_pkg::rdv_cfg_type [NUM_INPUTS-1:0] cfg_in,
    input wire logic fault_clear_in,
    // Results to the application
    output logic [NUM_INPUTS-1:0] voted_out,
    output logic [NUM_INPUTS-1:0] disc_fault_out,
    output rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] copy_disc_out,
    output logic [rdv_pkg::AREA_COUNT*NUM_INPUTS-1:0] image_out,
    // Sweep status and fault log
    output logic busy_out,
    output logic vote_done_out,
    output logic log_valid_out,
    output logic [NUM_INPUTS-1:0] log_mask_out
);

    // Copies that take part in a group of this kind
    function automatic rdv_pkg::rdv_copy_type group_mask(input rdv_pkg::rdv_group_type group);
        rdv_pkg::rdv_copy_type mask;
        mask = '0;
        unique case (group)
            rdv_pkg::GROUP_NONVOTED: mask = '0;
            rdv_pkg::GROUP_SIMPLEX: mask.a = 1'h1;
            rdv_pkg::GROUP_DUPLEX: mask = '{c: 1'h0, b: 1'h1, a: 1'h1};
            rdv_pkg::GROUP_TRIPLEX: mask = '{c: 1'h1, b: 1'h1, a: 1'h1};
        endcase
        return mask;
    endfunction : group_mask

    // Two-out-of-three majority
    function automatic logic majority(input logic x, input logic y, input logic z);
        return (x & y) | (x & z) | (y & z);
    endfunction : majority

    rdv_pkg::rdv_state_type state;
    rdv_pkg::rdv_state_type next_state;
    rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] cap_copy;
    rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] cap_fault;
    rdv_pkg::rdv_cfg_type [NUM_INPUTS-1:0] cap_cfg;
    logic [NUM_INPUTS-1:0] cap_nonvoted;
    logic [NUM_INPUTS-1:0] cap_reserved;

    wire logic take_scan;
    wire logic vote_now;
    wire logic [NUM_INPUTS-1:0] next_voted;
    wire logic [NUM_INPUTS-1:0] next_mismatch;
    wire logic [NUM_INPUTS-1:0] next_disc;
    wire rdv_pkg::rdv_copy_type [NUM_INPUTS-1:0] next_copy_disc;
    wire logic [NUM_INPUTS-1:0] area_a;
    wire logic [NUM_INPUTS-1:0] area_b;
    wire logic [NUM_INPUTS-1:0] area_c;

    // Vote terms per input, also read by the assertions
    wire logic [1:0] valid_count [NUM_INPUTS];
    wire logic [NUM_INPUTS-1:0] maj3;
    wire logic [NUM_INPUTS-1:0] pair_x;
    wire logic [NUM_INPUTS-1:0] pair_y;
    wire logic [NUM_INPUTS-1:0] lone;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    // Sweep sequencing
    assign take_scan = (state == rdv_pkg::ST_IDLE) && scan_done_in;
    assign vote_now = (state == rdv_pkg::ST_VOTE);

    always_comb begin
        next_state = state;
        unique case (state)
            rdv_pkg::ST_IDLE: if (scan_done_in) next_state = rdv_pkg::ST_VOTE;
            rdv_pkg::ST_VOTE: next_state = rdv_pkg::ST_REPORT;
            rdv_pkg::ST_REPORT: next_state = rdv_pkg::ST_IDLE;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i++) begin : g_input
            rdv_pkg::rdv_copy_type member;
            rdv_pkg::rdv_copy_type ok;
            rdv_pkg::rdv_copy_type differ;
            wire logic result;
            wire logic use_lone;

            assign member = group_mask(cap_cfg[i].group);
            assign ok = member & ~cap_fault[i] & ~copy_disc_out[i];
            assign valid_count[i] = {1'h0, ok.a} + {1'h0, ok.b} + {1'h0, ok.c};
            assign maj3[i] = majority(cap_copy[i].a, cap_copy[i].b, cap_copy[i].c);
            assign pair_x[i] = ok.a ? cap_copy[i].a : cap_copy[i].b;
            assign pair_y[i] = ok.c ? cap_copy[i].c : cap_copy[i].b;
            assign lone[i] = |(ok & cap_copy[i]);
            assign use_lone = (cap_cfg[i].group == rdv_pkg::GROUP_SIMPLEX) ||
                              (cap_cfg[i].adapt == rdv_pkg::ADAPT_FULL);

            assign result =
                (cap_cfg[i].group == rdv_pkg::GROUP_NONVOTED) ? cap_nonvoted[i] :
                (valid_count[i] == rdv_pkg::COUNT_ALL) ? maj3[i] :
                (valid_count[i] == rdv_pkg::COUNT_TWO) ?
                    majority(pair_x[i], pair_y[i], cap_cfg[i].tiebreak) :
                (valid_count[i] == rdv_pkg::COUNT_ONE && use_lone) ? lone[i] :
                cap_cfg[i].default_state;
            assign next_voted[i] = result;

            // Copies that took part yet disagree with the vote
            assign differ = ok & (cap_copy[i] ^ {3{result}});
            assign next_mismatch[i] = vote_now && (|differ);
            assign next_copy_disc[i] = (vote_now ? differ : '0) |
                                       (fault_clear_in ? '0 : copy_disc_out[i]);
            assign next_disc[i] = |next_copy_disc[i];

            assign area_a[i] = copy_in[i].a;
            assign area_b[i] = copy_in[i].b;
            assign area_c[i] = copy_in[i].c;

            triplex_majority_a: assert property (
                vote_now && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED && valid_count[i] == rdv_pkg::COUNT_ALL
                |=> voted_out[i] == ($countones($past(cap_copy[i])) > 1))
                else $error("three-copy vote is not the majority");
            triplex_ignores_tie_a: assert property (
                vote_now && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED && valid_count[i] == rdv_pkg::COUNT_ALL
                && maj3[i] != cap_cfg[i].tiebreak && maj3[i] != cap_cfg[i].default_state
                |=> voted_out[i] != $past(cap_cfg[i].default_state))
                else $error("tiebreak or default leaked into three-copy vote");
            duplex_or_a: assert property (
                vote_now && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED && valid_count[i] == rdv_pkg::COUNT_TWO
                && cap_cfg[i].tiebreak
                |=> voted_out[i] == ($past(pair_x[i]) | $past(pair_y[i])))
                else $error("two-copy vote with tiebreak one is not OR");
            duplex_and_a: assert property (
                vote_now && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED && valid_count[i] == rdv_pkg::COUNT_TWO
                && !cap_cfg[i].tiebreak
                |=> voted_out[i] == ($past(pair_x[i]) & $past(pair_y[i])))
                else $error("two-copy vote with tiebreak zero is not AND");
            nonvoted_pass_a: assert property (
                vote_now && cap_cfg[i].group == rdv_pkg::GROUP_NONVOTED
                |=> voted_out[i] == $past(cap_nonvoted[i]) && !log_mask_out[i])
                else $error("non-voted input not passed through");
            lone_copy_a: assert property (
                vote_now && valid_count[i] == rdv_pkg::COUNT_ONE && use_lone
                && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED
                |=> voted_out[i] == $past(lone[i]))
                else $error("lone copy not used directly");
            stop_default_a: assert property (
                vote_now && valid_count[i] <= rdv_pkg::COUNT_ONE
                && cap_cfg[i].group != rdv_pkg::GROUP_NONVOTED && (!use_lone || valid_count[i] == rdv_pkg::COUNT_NONE)
                |=> voted_out[i] == $past(cap_cfg[i].default_state))
                else $error("default state not applied");
            disc_latch_a: assert property (
                next_mismatch[i] |=> disc_fault_out[i] && log_valid_out && log_mask_out[i])
                else $error("discrepancy not flagged and logged");
            disc_sticky_a: assert property (
                disc_fault_out[i] && !fault_clear_in |=> disc_fault_out[i])
                else $error("discrepancy flag dropped without clear");
            simplex_copy_a: assert property (
                vote_now && cap_cfg[i].group == rdv_pkg::GROUP_SIMPLEX && valid_count[i] == rdv_pkg::COUNT_ONE
                |=> voted_out[i] == $past(cap_copy[i].a))
                else $error("valid simplex copy not used as the vote");
            simplex_fail_a: assert property (
                vote_now && cap_cfg[i].group == rdv_pkg::GROUP_SIMPLEX && valid_count[i] == rdv_pkg::COUNT_NONE
                |=> voted_out[i] == $past(cap_cfg[i].default_state))
                else $error("failed simplex copy did not give default");
            last_copy_a: assert property (
                vote_now && cap_cfg[i].group inside {rdv_pkg::GROUP_DUPLEX, rdv_pkg::GROUP_TRIPLEX}
                && cap_cfg[i].adapt == rdv_pkg::ADAPT_FULL && valid_count[i] == rdv_pkg::COUNT_NONE
                |=> voted_out[i] == $past(cap_cfg[i].default_state))
                else $error("group with no valid copy did not give default");
            duplex_stop_a: assert property (
                vote_now && cap_cfg[i].group == rdv_pkg::GROUP_DUPLEX
                && cap_cfg[i].adapt == rdv_pkg::ADAPT_STOP_AT_TWO && valid_count[i] != rdv_pkg::COUNT_TWO
                |=> voted_out[i] == $past(cap_cfg[i].default_state))
                else $error("stop-at-two duplex with a failed copy did not give default");
            triplex_stop_a: assert property (
                vote_now && cap_cfg[i].group == rdv_pkg::GROUP_TRIPLEX
                && cap_cfg[i].adapt == rdv_pkg::ADAPT_STOP_AT_TWO && valid_count[i] <= rdv_pkg::COUNT_ONE
                |=> voted_out[i] == $past(cap_cfg[i].default_state))
                else $error("stop-at-two triplex with two failures did not give default");
            fault_excluded_a: assert property (
                vote_now && (|cap_fault[i])
                |=> (copy_disc_out[i] & $past(cap_fault[i] & ~copy_disc_out[i])) == 3'h0)
                else $error("faulted copy took part in the vote");
            flag_clear_a: assert property (
                fault_clear_in && !vote_now |=> !disc_fault_out[i])
                else $error("discrepancy flag not cleared on request");
        end
    endgenerate

    // Vote result ready two cycles after the scan is accepted
    sequence scan_taken_s;
        take_scan;
    endsequence
    sequence vote_ready_s;
        busy_out ##1 (busy_out && vote_done_out);
    endsequence
    scan_to_vote_a: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        scan_taken_s |=> vote_ready_s)
        else $error("vote not completed two cycles after scan");

    // Reserved area of the image follows the captured inhibit bits
    image_reserved_a: assert property (
        vote_now |-> image_out[rdv_pkg::AREA_RESERVED*NUM_INPUTS +: NUM_INPUTS] == cap_reserved)
        else $error("reserved image area does not match the scan");

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state <= rdv_pkg::ST_IDLE;
            busy_out <= rdv_pkg::FLAG_RESET;
            vote_done_out <= rdv_pkg::FLAG_RESET;
        end else begin
            state <= next_state;
            busy_out <= (next_state != rdv_pkg::ST_IDLE);
            vote_done_out <= vote_now;
        end
    end

    // Input scan storage, copy areas and reserved area of the image
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            cap_copy <= '0;
            cap_fault <= '0;
            cap_cfg <= '0;
            cap_nonvoted <= '0;
            cap_reserved <= '0;
        end else if (take_scan) begin
            cap_copy <= copy_in;
            cap_fault <= selftest_fault_in | comm_fault_in;
            cap_cfg <= cfg_in;
            cap_nonvoted <= nonvoted_in;
            cap_reserved <= manual_inhibit_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            image_out <= '0;
        end else begin
            if (take_scan) begin
                image_out[rdv_pkg::AREA_COPY_A*NUM_INPUTS +: NUM_INPUTS] <= area_a;
                image_out[rdv_pkg::AREA_COPY_B*NUM_INPUTS +: NUM_INPUTS] <= area_b;
                image_out[rdv_pkg::AREA_COPY_C*NUM_INPUTS +: NUM_INPUTS] <= area_c;
                image_out[rdv_pkg::AREA_NONVOTED*NUM_INPUTS +: NUM_INPUTS] <= nonvoted_in;
                image_out[rdv_pkg::AREA_RESERVED*NUM_INPUTS +: NUM_INPUTS] <= manual_inhibit_in;
            end
            if (vote_now) begin
                image_out[rdv_pkg::AREA_VOTED*NUM_INPUTS +: NUM_INPUTS] <= next_voted;
            end
        end
    end

    // Voted results, latched discrepancies and fault log
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            voted_out <= {NUM_INPUTS{rdv_pkg::VOTED_RESET}};
            copy_disc_out <= '0;
            disc_fault_out <= '0;
            log_valid_out <= rdv_pkg::FLAG_RESET;
            log_mask_out <= '0;
        end else begin
            if (vote_now) begin
                voted_out <= next_voted;
            end
            copy_disc_out <= next_copy_disc;
            disc_fault_out <= next_disc;
            log_valid_out <= |next_mismatch;
            log_mask_out <= next_mismatch;
        end
    end

endmodule : rdv_voter

`default_nettype wire

// ### tb/rdv_scan_model.sv
`timescale 1ns/1ps
`default_nettype none

module rdv_scan_model #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Request from the bench
    input wire logic go_in,
    input wire logic [3:0] delay_in,
    input wire rdv_pkg::rdv_copy_type [N-1:0] data_in,
    // Scan towards the voter
    output logic scan_done_out,
    output rdv_pkg::rdv_copy_type [N-1:0] copy_out
);
    logic pending;
    logic [3:0] wait_count;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            pending <= 1'h0;
            wait_count <= 4'h0;
            scan_done_out <= 1'h0;
            copy_out <= '0;
        end else if (go_in && !pending) begin
            pending <= 1'h1;
            wait_count <= delay_in;
            scan_done_out <= 1'h0;
        end else if (pending && wait_count == 4'h0) begin
            // Copies stored and the scan flagged as done on the same edge
            pending <= 1'h0;
            scan_done_out <= 1'h1;
            copy_out <= data_in;
        end else begin
            // Released lines keep changing outside a scan
            wait_count <= pending ? wait_count - 4'h1 : 4'h0;
            scan_done_out <= 1'h0;
            copy_out <= ~copy_out;
        end
    end
endmodule : rdv_scan_model

`default_nettype wire

// ### tb/rdv_voter_tb.sv
`timescale 1ns/1ps
`default_nettype none

module rdv_voter_tb;
    localparam int N = 8;
    logic clock_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic go = 1'h0;
    logic clr = 1'h0;
    logic [3:0] delay = 4'h0;
    logic scan_done, busy, vdone, lvalid, log_seen;
    logic [N-1:0] nonv = '0, inh = '0, voted, disc, lmask, mask_seen;
    logic [6*N-1:0] image;
    rdv_pkg::rdv_copy_type [N-1:0] data = '0, copies, stf = '0, cmf = '0, cdisc;
    rdv_pkg::rdv_cfg_type [N-1:0] cfg = '0;
    int fails = 0;
    int checks_done = 0;

    always #5 clock_in = ~clock_in;

    rdv_scan_model #(.N(N)) model (.clock_in(clock_in), .reset_n_in(reset_n_in), .go_in(go),
        .delay_in(delay), .data_in(data), .scan_done_out(scan_done), .copy_out(copies));

    rdv_voter #(.NUM_INPUTS(N)) DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .scan_done_in(scan_done), .copy_in(copies), .nonvoted_in(nonv), .manual_inhibit_in(inh),
        .selftest_fault_in(stf), .comm_fault_in(cmf), .cfg_in(cfg), .fault_clear_in(clr),
        .voted_out(voted), .disc_fault_out(disc), .copy_disc_out(cdisc), .image_out(image),
        .busy_out(busy), .vote_done_out(vdone), .log_valid_out(lvalid), .log_mask_out(lmask));

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic setup(input logic [15:0] grp, input logic [7:0] adp, tbk, dft, a, b, c);
        @(posedge clock_in);
        for (int i = 0; i < N; i++) begin
            cfg[i] <= '{rdv_pkg::rdv_group_type'(grp[2*i +: 2]), rdv_pkg::rdv_adapt_type'(adp[i]),
                tbk[i], dft[i]};
            data[i] <= '{c[i], b[i], a[i]};
        end
    endtask : setup

    task automatic sweep(input logic [3:0] dly);
        int n;
        n = 0;
        @(posedge clock_in);
        go <= 1'h1;
        delay <= dly;
        @(posedge clock_in);
        go <= 1'h0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
        end while (scan_done !== 1'h1 && n < 30);
        check(n < 30, 1);
        @(posedge clock_in);
        #1;
        check({busy, vdone}, 2'h2);
        @(posedge clock_in);
        #1;
        check({busy, vdone}, 2'h3);
        log_seen = lvalid;
        mask_seen = lmask;
        @(posedge clock_in);
        #1;
        check({busy, vdone, lvalid}, 3'h0);
        check(lmask, 0);
    endtask : sweep

    task automatic clear_flags;
        @(posedge clock_in);
        clr <= 1'h1;
        @(posedge clock_in);
        clr <= 1'h0;
        #1;
        check(disc, 0);
        check(cdisc, 0);
    endtask : clear_flags

    task automatic t_triplex;
        setup(16'hffff, 8'h00, 8'hff, 8'hff, 8'haa, 8'hcc, 8'hf0);
        sweep(4'h0);
        check(voted, 8'he8);
        check(disc, 8'h7e);
        check({log_seen, mask_seen}, 9'h17e);
        check(cdisc, 24'h054888);
        setup(16'hffff, 8'h00, 8'hff, 8'hff, 8'h42, 8'h24, 8'h18);
        sweep(4'h5);
        check(voted, 8'h00);
        check(disc, 8'h7e);
        check({log_seen, mask_seen}, 9'h000);
        clear_flags();
    endtask : t_triplex

    task automatic t_duplex;
        setup(16'haaaa, 8'h00, 8'h0f, 8'hff, 8'haa, 8'hcc, 8'hff);
        sweep(4'h2);
        check(voted, 8'h8e);
        check(disc, 8'h66);
        check({log_seen, mask_seen}, 9'h166);
        clear_flags();
    endtask : t_duplex

    task automatic t_degrade;
        setup(16'hefd4, 8'h50, 8'h00, 8'h04, 8'he2, 8'h20, 8'hb8);
        nonv <= 8'h01;
        inh <= 8'h5a;
        for (int i = 0; i < N; i++) begin
            stf[i] <= '{i == 5, i == 3 || i == 4, i >= 2 && i <= 5};
            cmf[i] <= '{i == 7, i == 5 || i == 6, 1'h0};
        end
        sweep(4'h1);
        check(voted, 8'h0f);
        check({log_seen, mask_seen}, 9'h1d0);
        check(image[0 +: N], 8'h0f);
        check(image[N +: N], 8'he2);
        check(image[4*N +: N], 8'h01);
        check(image[5*N +: N], 8'h5a);
        clear_flags();
    endtask : t_degrade

    initial begin
        repeat (4) @(posedge clock_in);
        reset_n_in <= 1'h1;
        #1;
        check(image, 0);
        check({voted, disc, lmask, cdisc, busy, vdone, lvalid}, 0);
        t_triplex();
        t_duplex();
        t_degrade();
        stop_test();
    end

    // About forty times the expected length of the run
    initial begin
        #20000;
        fails++;
        stop_test();
    end
endmodule : rdv_voter_tb

`default_nettype wire
